// ---- hw/dhp_pkg.sv ----
// Constants and types shared by the demultiplexed parallel host port
`default_nettype none
package dhp_pkg;
    // ==========================================
    // Strap codes, ordered {two, three, four}
    localparam logic [2:0] STRAP_BYTE_RW  = 3'h0;
    localparam logic [2:0] STRAP_BYTE_EN  = 3'h1;
    localparam logic [2:0] STRAP_WORD_WR2 = 3'h4;
    localparam logic [2:0] STRAP_WORD_LN  = 3'h5;
    // ==========================================
    // Bus shape
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 15;
    localparam int IDX_W    = 14;
    localparam int MEM_WORDS = 16384;
    // ==========================================
    // Read access time
    localparam int ACCESS_NS = 75;
    localparam int CLK_NS    = 40;
    localparam int ACC_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ACC_LAST = 4'(ACC_CYC - 1);
    // ==========================================
    // Values after reset and filler
    localparam logic [15:0] FILL_WORD = 16'ha5a5;
    localparam logic [15:0] DATA_RST  = 16'h0000;
    localparam logic [3:0]  CNT_RST   = 4'h0;
    localparam logic [1:0]  MASK_RST  = 2'h0;
    localparam logic [13:0] IDX_RST   = 14'h0000;

    typedef enum logic [2:0] {
        DHP_MODE_OFF,
        DHP_MODE_A,
        DHP_MODE_B,
        DHP_MODE_C,
        DHP_MODE_D
    } dhp_mode_t;

    typedef enum logic [1:0] {
        DHP_ST_IDLE,
        DHP_ST_FILL,
        DHP_ST_DRIVE
    } dhp_state_t;
endpackage
`default_nettype wire

// ---- hw/dhp_ctl_if.sv ----
// Decoded strobe levels passed from decoder to port core
`timescale 1ns/1ns
`default_nettype none
interface dhp_ctl_if;
    logic rd_act;
    logic wr_lo;
    logic wr_hi;
    logic wide;
    modport decode (output rd_act, output wr_lo, output wr_hi, output wide);
    modport core   (input rd_act, input wr_lo, input wr_hi, input wide);
endinterface
`default_nettype wire

// ---- hw/dhp_decode.sv ----
// Strobe decoder for the four demultiplexed modes
`timescale 1ns/1ns
`default_nettype none
module dhp_decode (
    input  wire dhp_pkg::dhp_mode_t mode,
    input  wire logic               chip_select,
    input  wire logic               read_strobe,
    input  wire logic               write_strobe,
    input  wire logic               enable_strobe,
    input  wire logic               direction,
    input  wire logic               low_byte_write_strobe,
    input  wire logic               high_byte_write_strobe,
    input  wire logic               low_lane_select,
    input  wire logic               high_lane_select,
    dhp_ctl_if.decode               ctl
);
    logic either_lane_select;

    always_comb begin
        either_lane_select = low_lane_select | high_lane_select;
        ctl.rd_act = 1'b0;
        ctl.wr_lo  = 1'b0;
        ctl.wr_hi  = 1'b0;
        ctl.wide   = 1'b0;
        case (mode)
            dhp_pkg::DHP_MODE_A: begin
                ctl.rd_act = chip_select & read_strobe;
                ctl.wr_lo  = chip_select & write_strobe;
            end
            dhp_pkg::DHP_MODE_B: begin
                ctl.rd_act = chip_select & enable_strobe & direction;
                ctl.wr_lo  = chip_select & enable_strobe & ~direction;
            end
            dhp_pkg::DHP_MODE_C: begin
                ctl.wide   = 1'b1;
                ctl.rd_act = chip_select & read_strobe;
                ctl.wr_lo  = chip_select & low_byte_write_strobe;
                ctl.wr_hi  = chip_select & high_byte_write_strobe;
            end
            dhp_pkg::DHP_MODE_D: begin
                ctl.wide   = 1'b1;
                ctl.rd_act = chip_select & direction & either_lane_select;
                ctl.wr_lo  = chip_select & ~direction & low_lane_select;
                ctl.wr_hi  = chip_select & ~direction & high_lane_select;
            end
            default: begin
                ctl.rd_act = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- hw/dhp_parallel_host_port.sv ----
// Demultiplexed parallel host port core with strap decode and word store
`timescale 1ns/1ns
`default_nettype none
module dhp_parallel_host_port (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        mode_strap_two,
    input  wire logic        mode_strap_three,
    input  wire logic        mode_strap_four,
    input  wire logic        chip_select,
    input  wire logic        read_strobe,
    input  wire logic        write_strobe,
    input  wire logic        enable_strobe,
    input  wire logic        direction,
    input  wire logic        low_byte_write_strobe,
    input  wire logic        high_byte_write_strobe,
    input  wire logic        low_lane_select,
    input  wire logic        high_lane_select,
    input  wire logic [14:0] addr,
    input  wire logic [15:0] data_in,
    output var  logic [15:0] data_out,
    output logic      [15:0] data_oe
);
    // ==========================================
    // Strap capture
    function automatic dhp_pkg::dhp_mode_t strap_mode(input logic [2:0] s);
        case (s)
            dhp_pkg::STRAP_BYTE_RW:  strap_mode = dhp_pkg::DHP_MODE_A;
            dhp_pkg::STRAP_BYTE_EN:  strap_mode = dhp_pkg::DHP_MODE_B;
            dhp_pkg::STRAP_WORD_WR2: strap_mode = dhp_pkg::DHP_MODE_C;
            dhp_pkg::STRAP_WORD_LN:  strap_mode = dhp_pkg::DHP_MODE_D;
            default:                 strap_mode = dhp_pkg::DHP_MODE_OFF;
        endcase
    endfunction

    dhp_pkg::dhp_mode_t mode;
    dhp_pkg::dhp_mode_t next_mode;
    logic               strapped;
    logic               next_strapped;

    always_comb begin
        next_mode     = mode;
        next_strapped = strapped;
        if (!strapped) begin
            next_mode     = strap_mode({mode_strap_two, mode_strap_three, mode_strap_four});
            next_strapped = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode     <= dhp_pkg::DHP_MODE_OFF;
            strapped <= 1'b0;
        end else if (clk_en) begin
            mode     <= next_mode;
            strapped <= next_strapped;
        end
    end

    // ==========================================
    // Strobe decode
    dhp_ctl_if ctl ();

    dhp_decode u_decode (
        .mode                   (mode),
        .chip_select            (chip_select),
        .read_strobe            (read_strobe),
        .write_strobe           (write_strobe),
        .enable_strobe          (enable_strobe),
        .direction              (direction),
        .low_byte_write_strobe  (low_byte_write_strobe),
        .high_byte_write_strobe (high_byte_write_strobe),
        .low_lane_select        (low_lane_select),
        .high_lane_select       (high_lane_select),
        .ctl                    (ctl.decode)
    );

    // ==========================================
    // Word store
    logic [7:0]  mem_lo [0:dhp_pkg::MEM_WORDS-1];
    logic [7:0]  mem_hi [0:dhp_pkg::MEM_WORDS-1];
    logic [13:0] acc_idx;
    logic        acc_upper;

    always_comb begin
        if (ctl.wide) begin
            acc_idx   = addr[13:0];
            acc_upper = 1'b0;
        end else begin
            acc_idx   = addr[14:1];
            acc_upper = addr[0];
        end
    end

    // ==========================================
    // Write capture and commit on strobe fall
    logic        wr_pend;
    logic        next_wr_pend;
    logic [1:0]  wr_mask;
    logic [1:0]  next_wr_mask;
    logic [13:0] wr_idx;
    logic [13:0] next_wr_idx;
    logic [15:0] wr_data;
    logic [15:0] next_wr_data;
    logic [1:0]  we;
    logic        wr_any;

    always_comb begin
        wr_any       = ctl.wr_lo | ctl.wr_hi;
        next_wr_pend = wr_pend;
        next_wr_mask = wr_mask;
        next_wr_idx  = wr_idx;
        next_wr_data = wr_data;
        we           = 2'b00;
        if (wr_any) begin
            next_wr_pend = 1'b1;
            next_wr_idx  = acc_idx;
            if (ctl.wide) begin
                next_wr_data = data_in;
                next_wr_mask = wr_mask | {ctl.wr_hi, ctl.wr_lo};
            end else begin
                next_wr_data = {data_in[7:0], data_in[7:0]};
                next_wr_mask = acc_upper ? 2'b10 : 2'b01;
            end
        end else if (wr_pend) begin
            we           = wr_mask;
            next_wr_pend = 1'b0;
            next_wr_mask = dhp_pkg::MASK_RST;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_mask <= dhp_pkg::MASK_RST;
            wr_idx  <= dhp_pkg::IDX_RST;
            wr_data <= dhp_pkg::DATA_RST;
        end else if (clk_en) begin
            wr_pend <= next_wr_pend;
            wr_mask <= next_wr_mask;
            wr_idx  <= next_wr_idx;
            wr_data <= next_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en && we[0]) begin
            mem_lo[wr_idx] <= wr_data[7:0];
        end
        if (clk_en && we[1]) begin
            mem_hi[wr_idx] <= wr_data[15:8];
        end
    end

    // ==========================================
    // Read sequencing
    dhp_pkg::dhp_state_t st;
    dhp_pkg::dhp_state_t next_st;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic [13:0]         rd_idx;
    logic [13:0]         next_rd_idx;
    logic                rd_upper;
    logic                next_rd_upper;
    logic [15:0]         next_data_out;
    logic [15:0]         read_word;

    always_comb begin
        if (ctl.wide) begin
            read_word = {mem_hi[rd_idx], mem_lo[rd_idx]};
        end else if (rd_upper) begin
            read_word = {8'h00, mem_hi[rd_idx]};
        end else begin
            read_word = {8'h00, mem_lo[rd_idx]};
        end
    end

    always_comb begin
        next_st       = st;
        next_cnt      = cnt;
        next_rd_idx   = rd_idx;
        next_rd_upper = rd_upper;
        next_data_out = data_out;
        case (st)
            dhp_pkg::DHP_ST_IDLE: begin
                if (ctl.rd_act) begin
                    next_st       = dhp_pkg::DHP_ST_FILL;
                    next_cnt      = dhp_pkg::CNT_RST;
                    next_rd_idx   = acc_idx;
                    next_rd_upper = acc_upper;
                    next_data_out = dhp_pkg::FILL_WORD;
                end
            end
            dhp_pkg::DHP_ST_FILL: begin
                if (!ctl.rd_act) begin
                    next_st = dhp_pkg::DHP_ST_IDLE;
                end else if (cnt == dhp_pkg::ACC_LAST) begin
                    next_st       = dhp_pkg::DHP_ST_DRIVE;
                    next_data_out = read_word;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            dhp_pkg::DHP_ST_DRIVE: begin
                if (!ctl.rd_act) begin
                    next_st = dhp_pkg::DHP_ST_IDLE;
                end
            end
            default: begin
                next_st = dhp_pkg::DHP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st       <= dhp_pkg::DHP_ST_IDLE;
            cnt      <= dhp_pkg::CNT_RST;
            rd_idx   <= dhp_pkg::IDX_RST;
            rd_upper <= 1'b0;
            data_out <= dhp_pkg::DATA_RST;
        end else if (clk_en) begin
            st       <= next_st;
            cnt      <= next_cnt;
            rd_idx   <= next_rd_idx;
            rd_upper <= next_rd_upper;
            data_out <= next_data_out;
        end
    end

    // Output enables follow the decoded read level directly
    assign data_oe = {{8{ctl.rd_act & ctl.wide}}, {8{ctl.rd_act}}};

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_cs_low_float;
        !chip_select |-> data_oe == 16'h0000;
    endproperty
    a_cs_low_float: assert property (p_cs_low_float) else $error("Bus driven without select");

    property p_mode_b_float;
        (mode == dhp_pkg::DHP_MODE_B) && (!enable_strobe || !direction) |-> data_oe == 16'h0000;
    endproperty
    a_mode_b_float: assert property (p_mode_b_float) else $error("Mode B bus driven wrongly");

    property p_mode_c_drive;
        (mode == dhp_pkg::DHP_MODE_C) && chip_select && read_strobe |-> data_oe == 16'hffff;
    endproperty
    a_mode_c_drive: assert property (p_mode_c_drive) else $error("Mode C read not full width");

    property p_mode_d_float;
        (mode == dhp_pkg::DHP_MODE_D) && (!direction || !(low_lane_select || high_lane_select))
            |-> data_oe == 16'h0000;
    endproperty
    a_mode_d_float: assert property (p_mode_d_float) else $error("Mode D bus driven wrongly");

    property p_narrow_upper;
        (mode == dhp_pkg::DHP_MODE_A) || (mode == dhp_pkg::DHP_MODE_B) |-> data_oe[15:8] == 8'h00;
    endproperty
    a_narrow_upper: assert property (p_narrow_upper) else $error("Unused upper lane driven");

    sequence s_read_rise;
        (st == dhp_pkg::DHP_ST_IDLE) && ctl.rd_act && clk_en;
    endsequence
    sequence s_fill_done;
        (st == dhp_pkg::DHP_ST_FILL) && (cnt == dhp_pkg::ACC_LAST) && ctl.rd_act && clk_en;
    endsequence

    property p_fill_first;
        s_read_rise |=> (st == dhp_pkg::DHP_ST_FILL) && (data_out == dhp_pkg::FILL_WORD);
    endproperty
    a_fill_first: assert property (p_fill_first) else $error("Filler not driven at read start");

    property p_valid_after;
        s_fill_done |=> (st == dhp_pkg::DHP_ST_DRIVE) && (data_out == $past(read_word));
    endproperty
    a_valid_after: assert property (p_valid_after) else $error("Read data not presented");

    property p_release;
        (st != dhp_pkg::DHP_ST_IDLE) && !ctl.rd_act && clk_en |=> st == dhp_pkg::DHP_ST_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("Read not ended on strobe fall");

    property p_mode_fixed;
        strapped |=> $stable(mode);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("Mode changed during operation");

    property p_wide_read;
        (st == dhp_pkg::DHP_ST_DRIVE) && ctl.wide && ctl.rd_act |-> data_oe == 16'hffff;
    endproperty
    a_wide_read: assert property (p_wide_read) else $error("Word read not full width");
endmodule
`default_nettype wire

// ---- tb/dhp_host_model.sv ----
// Host bus model driving the demultiplexed parallel host port pins
`timescale 1ns/1ns
`default_nettype none
module dhp_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] bus,
    output logic      [7:0]  strobes,
    output logic             chip_select,
    output logic      [14:0] addr,
    output logic      [15:0] drv,
    output logic      [15:0] drv_oe
);
    // ==========================================
    // Strobes {read, write, enable, direction, lo_wr, hi_wr, lo_lane, hi_lane}
    initial begin
        strobes = 8'h00;
        chip_select = 1'b0;
        addr = 15'h0000;
        drv = 16'h0000;
        drv_oe = 16'h0000;
    end

    // ==========================================
    // One access; ln[0] low lane, ln[1] high lane
    task automatic access(input int m, input bit wr, input logic [14:0] a, input logic [15:0] d,
                          input logic [1:0] ln, output logic [15:0] fill, output logic [15:0] q);
        logic [7:0] s;
        fill = 16'h0000;
        q = 16'h0000;
        case (m)
            0: s = wr ? 8'h40 : 8'h80;
            1: s = wr ? 8'h20 : 8'h30;
            2: s = wr ? {4'h0, ln[0], ln[1], 2'h0} : 8'h80;
            default: s = {3'h0, !wr, 2'h0, ln[0], ln[1]};
        endcase
        @(posedge clk);
        chip_select <= 1'b1;
        addr <= a;
        strobes <= s & 8'h10;
        drv <= d;
        drv_oe <= wr ? ((m < 2) ? 16'h00ff : 16'hffff) : 16'h0000;
        @(posedge clk);
        strobes <= s;
        if (wr) begin
            @(posedge clk);
            strobes <= s & 8'h10;
        end else begin
            repeat (2) @(posedge clk);
            @(negedge clk);
            fill = bus;
            @(posedge clk);
            @(negedge clk);
            q = bus;
            @(posedge clk);
            strobes <= s & 8'h10;
        end
        @(posedge clk);
        chip_select <= 1'b0;
        strobes <= 8'h00;
        drv_oe <= 16'h0000;
    endtask

    // ==========================================
    // Static pin levels for float checks
    task automatic poke(input logic c, input logic [7:0] s);
        @(posedge clk);
        chip_select <= c;
        strobes <= s;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the demultiplexed parallel host port
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk;
    logic        rst;
    logic        clk_en;
    logic [2:0]  straps;
    logic [7:0]  strobes;
    logic        chip_select;
    logic [14:0] addr;
    logic [15:0] drv;
    logic [15:0] drv_oe;
    logic [15:0] idle_pat;
    logic [15:0] data_out;
    logic [15:0] data_oe;
    wire  [15:0] bus;
    logic        byte_mode;
    logic        off_mode;
    logic [15:0] fill;
    logic [15:0] q;
    int          n_mismatch;
    int          samples_checked;

    // ==========================================
    // Bus level from both parties, floating bus toggles
    assign bus = (data_oe & data_out) | (~data_oe & drv_oe & drv) | (~data_oe & ~drv_oe & idle_pat);

    dhp_parallel_host_port u_dhp_parallel_host_port (
        .clk                    (clk),
        .rst                    (rst),
        .clk_en                 (clk_en),
        .mode_strap_two         (straps[2]),
        .mode_strap_three       (straps[1]),
        .mode_strap_four        (straps[0]),
        .chip_select            (chip_select),
        .read_strobe            (strobes[7]),
        .write_strobe           (strobes[6]),
        .enable_strobe          (strobes[5]),
        .direction              (strobes[4]),
        .low_byte_write_strobe  (strobes[3]),
        .high_byte_write_strobe (strobes[2]),
        .low_lane_select        (strobes[1]),
        .high_lane_select       (strobes[0]),
        .addr                   (addr),
        .data_in                (bus),
        .data_out               (data_out),
        .data_oe                (data_oe)
    );

    dhp_host_model u_dhp_host_model (
        .clk         (clk),
        .bus         (bus),
        .strobes     (strobes),
        .chip_select (chip_select),
        .addr        (addr),
        .drv         (drv),
        .drv_oe      (drv_oe)
    );

    always #20 clk = ~clk;
    always @(posedge clk) idle_pat <= ~idle_pat;

    // ==========================================
    // Compare and report
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // Pin monitors
    always @(negedge clk) begin
        check16("overlap", 16'h0000, drv_oe & data_oe);
        if (!chip_select || off_mode)
            check16("idle_oe", 16'h0000, data_oe);
        if (byte_mode)
            check16("upper_oe", 16'h0000, {data_oe[15:8], 8'h00});
        if (!strobes[7] && !strobes[5] && (strobes[1:0] == 2'h0))
            check16("strobe_low_oe", 16'h0000, data_oe);
    end

    // ==========================================
    // Helpers
    task automatic restart(input logic [2:0] s);
        @(posedge clk);
        byte_mode = (s == dhp_pkg::STRAP_BYTE_RW) || (s == dhp_pkg::STRAP_BYTE_EN);
        off_mode = !byte_mode && (s != dhp_pkg::STRAP_WORD_WR2) && (s != dhp_pkg::STRAP_WORD_LN);
        straps <= s;
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic wr(input int m, input logic [14:0] a, input logic [15:0] d, input logic [1:0] ln);
        u_dhp_host_model.access(m, 1'b1, a, d, ln, fill, q);
    endtask

    task automatic rd_chk(input int m, input logic [14:0] a, input logic [1:0] ln, input logic [15:0] exp);
        logic [15:0] k;
        k = (m < 2) ? 16'h00ff : 16'hffff;
        u_dhp_host_model.access(m, 1'b0, a, 16'h0000, ln, fill, q);
        check16("fill", dhp_pkg::FILL_WORD & k, fill & k);
        check16("read", exp, q & k);
        @(negedge clk);
        check16("release", 16'h0000, data_oe);
    endtask

    task automatic float_chk(input logic c, input logic [7:0] s);
        u_dhp_host_model.poke(c, s);
        @(negedge clk);
        check16("float", 16'h0000, data_oe);
        u_dhp_host_model.poke(1'b0, 8'h00);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_mode_a();
        restart(dhp_pkg::STRAP_BYTE_RW);
        wr(0, 15'h0010, 16'h003c, 2'h0);
        wr(0, 15'h0011, 16'h00c3, 2'h0);
        rd_chk(0, 15'h0011, 2'h0, 16'h00c3);
        float_chk(1'b0, 8'h80);
        straps <= dhp_pkg::STRAP_WORD_WR2;
        rd_chk(0, 15'h0010, 2'h0, 16'h003c);
    endtask

    task automatic t_mode_b();
        restart(dhp_pkg::STRAP_BYTE_EN);
        wr(1, 15'h7ffe, 16'h0081, 2'h0);
        wr(1, 15'h7fff, 16'h007e, 2'h0);
        rd_chk(1, 15'h7ffe, 2'h0, 16'h0081);
        rd_chk(1, 15'h7fff, 2'h0, 16'h007e);
        float_chk(1'b1, 8'h10);
        float_chk(1'b0, 8'h30);
    endtask

    task automatic t_mode_c();
        restart(dhp_pkg::STRAP_WORD_WR2);
        wr(2, 15'h0005, 16'hbeef, 2'h3);
        wr(2, 15'h0006, 16'h1234, 2'h3);
        wr(2, 15'h0005, 16'h0011, 2'h1);
        wr(2, 15'h0005, 16'h2200, 2'h2);
        rd_chk(2, 15'h4005, 2'h0, 16'h2211);
        rd_chk(2, 15'h0006, 2'h0, 16'h1234);
    endtask

    task automatic t_mode_d();
        restart(dhp_pkg::STRAP_WORD_LN);
        wr(3, 15'h3fff, 16'hcafe, 2'h3);
        wr(3, 15'h3fff, 16'h00aa, 2'h1);
        wr(3, 15'h3fff, 16'h5500, 2'h2);
        rd_chk(3, 15'h3fff, 2'h1, 16'h55aa);
        rd_chk(3, 15'h3fff, 2'h2, 16'h55aa);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(3, 15'h3fff, 16'h0000, 2'h3);
        clk_en <= 1'b1;
        rd_chk(3, 15'h3fff, 2'h3, 16'h55aa);
        float_chk(1'b1, 8'h10);
        float_chk(1'b1, 8'h03);
    endtask

    task automatic t_bad_strap();
        restart(3'h2);
        u_dhp_host_model.access(0, 1'b0, 15'h0001, 16'h0000, 2'h0, fill, q);
        wr(0, 15'h000a, 16'h0077, 2'h0);
        restart(dhp_pkg::STRAP_WORD_WR2);
        rd_chk(2, 15'h0005, 2'h0, 16'h2211);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        straps = 3'h0;
        idle_pat = 16'h5a3c;
        n_mismatch = 0;
        samples_checked = 0;
        byte_mode = 1'b0;
        off_mode = 1'b1;
        clk_en = 1'b1;
        t_mode_a();
        t_mode_b();
        t_mode_c();
        t_mode_d();
        t_bad_strap();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
